/* pirs_pkg.sv */
// Purpose: Shared constants for the port init and interrupt status register bank
// Assumes: One clock, asynchronous active-high reset, 32-bit register words
// Notes: Both ends, the event block, the monitor and the bench import this package
// What this block does
// - Port control at 0374h, bits 31:24 reserved
// - Writing bit 23 clears bits 23 and 7
// - Software keeps init flag zero after power-up; the bench sets it in its port write checks
// - Init flag affects only the first port
// - Software sets power field to 11b
// - Software writes 0080_0018h after power-on
// - Status at 0310h holds seven event flags
// - Status flags clear only on written ones
// - Software clears flags before enabling events
// - Flags set regardless of master enable
// - Software writes reserved status bits zero
// - Port control upper half mirrors lower half
// - Interrupt line gated by enable mask
package pirs_pkg;
	// Device register map (byte addresses)
	localparam logic [11:0] PIRS_OFS_IRQ_STATUS = 12'h310;
	localparam logic [11:0] PIRS_OFS_IRQ_MASK = 12'h314;
	localparam logic [11:0] PIRS_OFS_PORT_CTRL = 12'h374;
	// Port control fields
	localparam int PIRS_BIT_INIT_CLEAR = 23;
	localparam int PIRS_BIT_INIT_FLAG = 7;
	localparam int PIRS_POS_POWER = 3;
	localparam logic [15:0] PIRS_PORT_HALF_MASK = 16'h0098;
	localparam logic [15:0] PIRS_PORT_RESET_HALF = 16'h0006;
	localparam logic [31:0] PIRS_PORT_INIT_WORD = 32'h0080_0018;
	localparam logic [1:0] PIRS_POWER_ON = 2'h3;
	// Interrupt status fields
	localparam int PIRS_NUM_EVENTS = 7;
	localparam logic [31:0] PIRS_IRQ_VALID_MASK = 32'h0000_03EA;
	localparam logic [31:0] PIRS_IRQ_RESET = 32'h0000_0000;
	// Controller register map (byte offsets)
	localparam logic [3:0] PIRS_C_CMD = 4'h0;
	localparam logic [3:0] PIRS_C_STATUS = 4'h4;
	localparam logic [3:0] PIRS_C_IRQ = 4'h8;
	localparam logic [3:0] PIRS_C_MASK = 4'hC;
	localparam logic [3:0] PIRS_C_EVENTS = 4'h0;
	// Bit position of event index n in the status word
	function automatic int pirs_event_pos(input int n);
		case (n)
			0: return 1;
			1: return 3;
			2: return 5;
			3: return 6;
			4: return 7;
			5: return 8;
			default: return 9;
		endcase
	endfunction
endpackage

/* pirs_if.sv */
// Purpose: Register access path between controller and device
// Assumes: Single cycle writes, read data one cycle after read strobe
// Notes: One modport for each party
`timescale 1ns/1ps
interface pirs_if;
	logic [11:0] addr; // Byte address
	logic [31:0] wdata; // Write data
	logic wr; // Write strobe
	logic rd; // Read strobe
	logic [31:0] rdata; // Read data, cycle after rd
	modport device (input addr, input wdata, input wr, input rd, output rdata);
	modport ctrl (output addr, output wdata, output wr, output rd, input rdata);
endinterface // pirs_if

/* pirs_ctrl.sv */
// Purpose: Controller end that initializes the first port and services status
// Assumes: Software register port with read data one cycle later
// Notes: Runs the power-on init write, then forwards commands
`timescale 1ns/1ps
module pirs_ctrl (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Software port
	input wire logic [3:0] i_sw_addr,
	input wire logic [31:0] i_sw_wdata,
	input wire logic i_sw_wr,
	input wire logic i_sw_rd,
	output logic [31:0] o_sw_rdata,
	output logic o_irq,
	// Device link
	pirs_if.ctrl bus
);
	import pirs_pkg::*;
	logic init_done; // Init word written
	logic [31:0] cmd; // Bits 11:0 address, 12 write, 13 read
	logic [31:0] wdat; // Pending write data
	logic rd_pend; // Read answer due
	logic [31:0] last_rd; // Last device read data
	logic [1:0] ctl_irq; // Bit0 init done, bit1 read done
	logic [1:0] ctl_mask; // Interrupt mask
	// Drive device strobes; init write has priority after reset
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			init_done <= 1'b0;
			bus.addr <= 12'h000;
			bus.wdata <= 32'h0000_0000;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
		end else if (!init_done) begin
			init_done <= 1'b1;
			bus.addr <= PIRS_OFS_PORT_CTRL;
			bus.wdata <= PIRS_PORT_INIT_WORD;
			bus.wr <= 1'b1;
			bus.rd <= 1'b0;
		end else begin
			// Software command word launches one access
			bus.wr <= i_sw_wr && i_sw_addr == PIRS_C_CMD && i_sw_wdata[12];
			bus.rd <= i_sw_wr && i_sw_addr == PIRS_C_CMD && !i_sw_wdata[12] && i_sw_wdata[13];
			if (i_sw_wr && i_sw_addr == PIRS_C_CMD) begin
				bus.addr <= i_sw_wdata[11:0];
			end
			bus.wdata <= wdat;
		end
	end
	// Command and data staging registers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cmd <= 32'h0000_0000;
			wdat <= 32'h0000_0000;
			ctl_mask <= 2'h0;
		end else if (i_sw_wr) begin
			if (i_sw_addr == PIRS_C_CMD) cmd <= i_sw_wdata;
			if (i_sw_addr == PIRS_C_STATUS) wdat <= i_sw_wdata;
			if (i_sw_addr == PIRS_C_MASK) ctl_mask <= i_sw_wdata[1:0];
		end
	end
	// Catch device read data; set wins over write-one clear
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rd_pend <= 1'b0;
			last_rd <= 32'h0000_0000;
			ctl_irq <= 2'h0;
		end else begin
			rd_pend <= bus.rd;
			if (rd_pend) last_rd <= bus.rdata;
			ctl_irq <= (ctl_irq & ~((i_sw_wr && i_sw_addr == PIRS_C_IRQ) ? i_sw_wdata[1:0] : 2'h0))
				| {rd_pend, !init_done}; // Bit0 marks the edge that launches the init write
		end
	end
	// Software read port, data one cycle after strobe
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_sw_rdata <= 32'h0000_0000;
		end else if (i_sw_rd) begin
			unique case (i_sw_addr)
				PIRS_C_CMD: o_sw_rdata <= cmd;
				PIRS_C_STATUS: o_sw_rdata <= last_rd;
				PIRS_C_IRQ: o_sw_rdata <= {30'h0, ctl_irq};
				PIRS_C_MASK: o_sw_rdata <= {30'h0, ctl_mask};
				default: o_sw_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_sw_rdata <= 32'h0000_0000;
		end
	end
	assign o_irq = |(ctl_irq & ctl_mask);
endmodule // pirs_ctrl

/* pirs_events.sv */
// Purpose: Sticky event flags with write-one clear and mask gating
// Assumes: Events are one-cycle pulses in the system clock domain
// Notes: Flags set regardless of any master enable
`timescale 1ns/1ps
module pirs_events (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Events and clear
	input wire logic [pirs_pkg::PIRS_NUM_EVENTS-1:0] i_event,
	input wire logic i_clr,
	input wire logic [31:0] i_clr_data,
	input wire logic [31:0] i_mask,
	// Flags
	output logic [31:0] o_status,
	output logic o_irq
);
	import pirs_pkg::*;
	logic [PIRS_NUM_EVENTS-1:0] flag; // One sticky flag per event, in event order
	logic [31:0] status; // Flags placed at their word positions
	genvar g;
	// One flag per event; set wins over clear, a written zero leaves the flag
	for (g = 0; g < PIRS_NUM_EVENTS; g++) begin : g_ev
		localparam int P = pirs_event_pos(g); // Word position of this event
		always_ff @(posedge i_clk_sys or posedge i_rst) begin
			if (i_rst) begin
				flag[g] <= 1'b0;
			end else if (i_event[g]) begin
				flag[g] <= 1'b1; // A lost event would hide finished work from software
			end else if (i_clr && i_clr_data[P]) begin
				flag[g] <= 1'b0;
			end
		end
	end
	// Spread the flags over the word; reserved positions stay zero
	always_comb begin
		status = PIRS_IRQ_RESET;
		for (int n = 0; n < PIRS_NUM_EVENTS; n++) begin
			status[pirs_event_pos(n)] = flag[n];
		end
	end
	assign o_status = status;
	assign o_irq = |(status & i_mask);
endmodule // pirs_events

/* pirs_dev.sv */
// Purpose: Device end holding port control and interrupt status registers
// Assumes: Accesses from the controller over pirs_if
// Notes: Only the first port sees the init flag
`timescale 1ns/1ps
module pirs_dev (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Register link
	pirs_if.device bus,
	// Events
	input wire logic [pirs_pkg::PIRS_NUM_EVENTS-1:0] i_event,
	// Port outputs
	output logic [1:0] o_first_port_power_field,
	output logic o_first_port_init_flag,
	output logic o_first_port_enable,
	output logic o_irq
);
	import pirs_pkg::*;
	logic [15:0] port_half; // Stored half, mirrored in both halves
	logic [31:0] irq_enable_mask; // Event mask
	logic [31:0] status; // Event flags
	logic wr_port; // Write to port control
	assign wr_port = bus.wr && bus.addr == PIRS_OFS_PORT_CTRL;
	// Port control; clear bit drops flag, reserved bits keep value
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			port_half <= PIRS_PORT_RESET_HALF;
		end else if (wr_port) begin
			port_half <= (port_half & ~PIRS_PORT_HALF_MASK) | (bus.wdata[15:0] & PIRS_PORT_HALF_MASK);
			if (bus.wdata[PIRS_BIT_INIT_CLEAR]) port_half[PIRS_BIT_INIT_FLAG] <= 1'b0;
		end
	end
	// Mask register
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) irq_enable_mask <= 32'h0000_0000;
		else if (bus.wr && bus.addr == PIRS_OFS_IRQ_MASK) irq_enable_mask <= bus.wdata & PIRS_IRQ_VALID_MASK;
	end
	pirs_events u_events (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_event(i_event),
		.i_clr(bus.wr && bus.addr == PIRS_OFS_IRQ_STATUS),
		.i_clr_data(bus.wdata),
		.i_mask(irq_enable_mask),
		.o_status(status),
		.o_irq(o_irq)
	);
	// Read data one cycle after strobe; halves mirror
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) bus.rdata <= 32'h0000_0000;
		else if (bus.rd) begin
			unique case (bus.addr)
				PIRS_OFS_PORT_CTRL: bus.rdata <= {port_half, port_half};
				PIRS_OFS_IRQ_STATUS: bus.rdata <= status;
				PIRS_OFS_IRQ_MASK: bus.rdata <= irq_enable_mask;
				default: bus.rdata <= 32'h0000_0000;
			endcase
		end else bus.rdata <= 32'h0000_0000;
	end
	// Port outputs; enable needs power 11b and flag clear
	assign o_first_port_power_field = port_half[PIRS_POS_POWER +: 2];
	assign o_first_port_init_flag = port_half[PIRS_BIT_INIT_FLAG];
	assign o_first_port_enable = port_half[PIRS_POS_POWER +: 2] == PIRS_POWER_ON && !port_half[PIRS_BIT_INIT_FLAG];
endmodule // pirs_dev

/* pirs_monitor.sv */
// Purpose: Link checker between controller and device
// Assumes: One clock, async active-high reset
// Notes: Device state is judged through its reads
`timescale 1ns/1ps
module pirs_monitor (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Link
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] i_rdata
);
	import pirs_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic pw, pr, stw, str; // Port and status strobes
	assign pw = i_wr && i_addr == PIRS_OFS_PORT_CTRL;
	assign pr = i_rd && i_addr == PIRS_OFS_PORT_CTRL;
	assign stw = i_wr && i_addr == PIRS_OFS_IRQ_STATUS;
	assign str = i_rd && i_addr == PIRS_OFS_IRQ_STATUS;
	// Paired checks write then read at once, so nothing else can touch the word
	port_mirror_a: assert property (pr |=> i_rdata[31:16] == i_rdata[15:0])
		else $error("port halves differ");
	port_reserved_a: assert property (pr |=> i_rdata[15:8] == 8'h00 && i_rdata[6:5] == 2'h0 && i_rdata[2:0] == 3'h6)
		else $error("port reserved moved");
	init_clear_a: assert property (pw && i_wdata[23] ##1 pr |=> !i_rdata[7] && !i_rdata[23])
		else $error("init flag kept");
	init_flag_a: assert property (pw && i_wdata[7] && !i_wdata[23] ##1 pr |=> i_rdata[7])
		else $error("init flag lost");
	power_store_a: assert property (pw ##1 pr |=> ((i_rdata ^ $past(i_wdata, 2)) & 32'h18) == 32'h0)
		else $error("power field wrong");
	init_word_a: assert property ($fell(i_rst) |-> ##[0:2] (pw && i_wdata == PIRS_PORT_INIT_WORD))
		else $error("no init write");
	stat_reserved_a: assert property (str |=> (i_rdata & ~PIRS_IRQ_VALID_MASK) == 32'h0)
		else $error("status reserved set");
	// Holds only while no event lands between clear and read; the bench keeps them apart
	stat_w1c_a: assert property (stw ##1 str |=> (i_rdata & $past(i_wdata, 2)) == 32'h0)
		else $error("flag not cleared");
	stat_zero_a: assert property (stw |-> (i_wdata & ~PIRS_IRQ_VALID_MASK) == 32'h0)
		else $error("status reserved written");
	cover property (pw ##1 pr);
	cover property (stw ##1 str);
	cover property ($fell(i_rst) ##[0:2] pw);
endmodule // pirs_monitor

/* pirs_test.sv */
// Purpose: Self-checking bench for both ends joined by the link
// Assumes: 50 MHz clock, LFSR seeded with 10909
// Notes: Device registers are reached only through the command port; event pulses drive the device directly
`timescale 1ns/1ps
module pirs_test;
	import pirs_pkg::*;
	logic i_clk_sys = 1'b0, i_rst = 1'b1; // Clock and reset
	logic [3:0] i_sw_addr = 4'h0; // Software port
	logic [31:0] i_sw_wdata = 32'h0, o_sw_rdata, v, d;
	logic i_sw_wr = 1'b0, i_sw_rd = 1'b0;
	logic [6:0] ev = 7'h0; // Event pulses
	logic [1:0] pwr; // Port outputs
	logic flag, en, dirq, cirq;
	int mismatches = 0, n_tests = 0;
	logic [15:0] seed = 16'h2A9D;
	int pos[7] = '{1, 3, 5, 6, 7, 8, 9}; // Flag bit of each event
	pirs_if bus_if();
	pirs_ctrl i_pirs_ctrl(.i_clk_sys, .i_rst, .i_sw_addr, .i_sw_wdata, .i_sw_wr, .i_sw_rd, .o_sw_rdata,
		.o_irq(cirq), .bus(bus_if));
	pirs_dev i_pirs_dev(.i_clk_sys, .i_rst, .bus(bus_if), .i_event(ev), .o_first_port_power_field(pwr),
		.o_first_port_init_flag(flag), .o_first_port_enable(en), .o_irq(dirq));
	pirs_monitor i_pirs_monitor(.i_clk_sys, .i_rst, .i_addr(bus_if.addr), .i_wdata(bus_if.wdata), .i_wr(bus_if.wr),
		.i_rd(bus_if.rd), .i_rdata(bus_if.rdata));
	initial begin
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Port readback: bits 7,4,3 kept, bit 23 wins over bit 7
	function automatic logic [31:0] port_exp(input logic [31:0] w);
		logic [15:0] h;
		h = 16'h0006 | (w[15:0] & 16'h0018) | (w[23] ? 16'h0000 : w[15:0] & 16'h0080);
		return {h, h};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One software cycle, driven right after an edge
	task automatic sw(input logic w, input logic r, input logic [3:0] a, input logic [31:0] x);
		i_sw_wr <= w;
		i_sw_rd <= r;
		i_sw_addr <= a;
		i_sw_wdata <= x;
		@(posedge i_clk_sys);
	endtask
	task automatic swr(input logic [3:0] a, output logic [31:0] q);
		sw(1'b0, 1'b1, a, 32'h0);
		// Strobe drops right after the edge; data stand only in this cycle
		i_sw_rd <= 1'b0;
		@(negedge i_clk_sys) q = o_sw_rdata;
		@(posedge i_clk_sys);
	endtask
	// Optional write, optional readback straight after, event pulse beside the write
	task automatic dev(input logic [11:0] a, input logic [31:0] x, input logic w, input logic r,
		input logic [6:0] e, output logic [31:0] q);
		sw(w, 1'b0, 4'h4, x);
		sw(w, 1'b0, PIRS_C_CMD, {20'h1, a});
		ev <= e;
		sw(r, 1'b0, PIRS_C_CMD, {20'h2, a});
		ev <= 7'h0;
		repeat (3) sw(1'b0, 1'b0, 4'h0, 32'h0);
		swr(4'h4, q);
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		mismatches++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (3) sw(1'b0, 1'b0, 4'h0, 32'h0);
		dev(PIRS_OFS_PORT_CTRL, 32'h0, 1'b0, 1'b1, 7'h0, v);
		chk(v, port_exp(PIRS_PORT_INIT_WORD));
		chk(32'({flag, en, pwr}), 32'h7);
		swr(PIRS_C_IRQ, v);
		chk(v & 32'h3, 32'h3);
		// Controller interrupt: open bit0, then clear both flags by writing ones
		sw(1'b1, 1'b0, PIRS_C_MASK, 32'h1);
		sw(1'b0, 1'b0, 4'h0, 32'h0);
		chk(32'(cirq), 32'h1);
		sw(1'b1, 1'b0, PIRS_C_IRQ, 32'h3);
		sw(1'b0, 1'b0, 4'h0, 32'h0);
		chk(32'(cirq), 32'h0);
		swr(PIRS_C_IRQ, v);
		chk(v, 32'h0);
		swr(PIRS_C_MASK, v);
		chk(v, 32'h1);
		// Corner words first: flag set with power half on, flag set with power on
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			d = (i < 2) ? (i ? 32'hFF7F_FFFF : 32'h0000_0088) : {seed, lfsr(seed)};
			dev(PIRS_OFS_PORT_CTRL, d, 1'b1, 1'b1, 7'h0, v);
			chk(v, port_exp(d));
			chk(32'({flag, en}), 32'({d[7] & !d[23], d[4:3] == 2'h3 && !(d[7] & !d[23])}));
		end
		// Every event with the mask closed, a zero write, then a one write
		for (int k = 0; k < 7; k++) begin
			dev(12'h0, 32'h0, 1'b0, 1'b0, 7'(1 << k), v);
			dev(PIRS_OFS_IRQ_STATUS, 32'h0, 1'b1, 1'b1, 7'h0, v);
			chk(v, 32'h1 << pos[k]);
			chk(32'(dirq), 32'h0);
			dev(PIRS_OFS_IRQ_STATUS, v, 1'b1, 1'b1, 7'h0, v);
			chk(v, 32'h0);
		end
		dev(PIRS_OFS_IRQ_MASK, 32'h100, 1'b1, 1'b0, 7'h20, v);
		chk(32'(dirq), 32'h1);
		dev(PIRS_OFS_IRQ_STATUS, 32'h100, 1'b1, 1'b0, 7'h20, v);
		dev(PIRS_OFS_IRQ_STATUS, 32'h0, 1'b0, 1'b1, 7'h0, v);
		chk(v, 32'h100);
		dev(PIRS_OFS_IRQ_STATUS, v, 1'b1, 1'b1, 7'h0, v);
		chk(v, 32'h0);
		chk(32'(dirq), 32'h0);
		dev(12'h3F0, 32'h0, 1'b0, 1'b1, 7'h0, v);
		chk(v, 32'h0);
		close_out();
	end
endmodule // pirs_test
